/* File: acrb_config_bank.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "acrb_regs.svh"

module acrb_config_bank
  import acrb_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5a  // arbitrary identity value
)(
  // clock, reset, clock enable
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // core status inputs
  input  wire logic [3:0]  STATUS_IN,
  input  wire logic [4:0]  PIN_IN,
  input  wire logic        MOD_TICK,
  // decoded controls
  output logic [7:0]       DELAYED_CLK_EN,
  output logic             FIRST_GROUP_CHOP,
  output logic             SECOND_GROUP_CHOP,
  output logic [3:0]       STANDBY,
  output logic [4:0]       PIN_OUT,
  output logic [4:0]       PIN_OE
);

  // apb request and register storage
  acrb_apb_req_t    req;
  logic [7:0]       standby_r;
  logic [7:0]       grpa_filt;
  logic [7:0]       grpb_filt;
  logic [7:0]       grp_assign;
  logic [7:0]       power_if;
  logic [7:0]       gen_cfg;
  logic [7:0]       conv_ctrl;
  logic [7:0]       out_if;
  logic [7:0]       self_test;
  logic [7:0]       pin_dir;
  logic [7:0]       pin_out_r;
  logic [7:0]       prebuf_01;
  logic [7:0]       prebuf_23;
  logic [7:0]       refp_buf;
  logic [7:0]       refn_buf;
  logic [7:0]       ch0_ofs;
  logic [7:0]       mod_delay;
  logic [7:0]       chop_ctrl;

  // synchroniser stages
  logic [4:0]       pin_meta;
  logic [4:0]       pin_sync;
  logic [3:0]       stat_meta;
  logic [3:0]       stat_sync;

  // decode, strobes and read data
  logic [6:0]       idx;
  logic             aligned;
  logic             hit;
  logic             setup_ph;
  logic             wr_stb;
  logic             rd_stb;
  logic [7:0]       wr_byte;
  logic [7:0]       rd_byte;
  logic             known;

  // per-register write enables
  logic             we_standby;
  logic             we_grpa_filt;
  logic             we_grpb_filt;
  logic             we_grp_assign;
  logic             we_power_if;
  logic             we_gen_cfg;
  logic             we_conv_ctrl;
  logic             we_out_if;
  logic             we_self_test;
  logic             we_pin_dir;
  logic             we_pin_out;
  logic             we_prebuf_01;
  logic             we_prebuf_23;
  logic             we_refp_buf;
  logic             we_refn_buf;
  logic             we_ch0_ofs;
  logic             we_mod_delay;
  logic             we_chop;

  // delayed clock and chop controls
  logic             dly_low4;
  logic             dly_high4;
  logic [7:0]       next_dly_en;
  acrb_dly_sel_t    dly_sel;
  acrb_chop_t       grpa_rate;
  acrb_chop_t       grpb_rate;
  acrb_chop_phase_t chop_ph;

  // bundle the request
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                 addr: PADDR, wdata: PWDATA};

  // address decode: word aligned, index below 0x80
  assign idx      = req.addr[8:2];
  assign aligned  = (req.addr[1:0] == 2'b00) && (req.addr[31:9] == 23'h0);
  assign hit      = aligned && known;
  assign setup_ph = req.sel && !req.enable;
  assign wr_stb   = CE && req.sel && req.enable && req.write && hit;
  assign rd_stb   = CE && setup_ph && !req.write;
  assign wr_byte  = req.wdata[7:0];

  // one write enable per storage register; read-only ones have none
  assign we_standby    = wr_stb && (idx == `ACRB_IDX_STANDBY);
  assign we_grpa_filt  = wr_stb && (idx == `ACRB_IDX_GRPA_FILT);
  assign we_grpb_filt  = wr_stb && (idx == `ACRB_IDX_GRPB_FILT);
  assign we_grp_assign = wr_stb && (idx == `ACRB_IDX_GRP_ASSIGN);
  assign we_power_if   = wr_stb && (idx == `ACRB_IDX_POWER_IF);
  assign we_gen_cfg    = wr_stb && (idx == `ACRB_IDX_GEN_CFG);
  assign we_conv_ctrl  = wr_stb && (idx == `ACRB_IDX_CONV_CTRL);
  assign we_out_if     = wr_stb && (idx == `ACRB_IDX_OUT_IF);
  assign we_self_test  = wr_stb && (idx == `ACRB_IDX_SELF_TEST);
  assign we_pin_dir    = wr_stb && (idx == `ACRB_IDX_PIN_DIR);
  assign we_pin_out    = wr_stb && (idx == `ACRB_IDX_PIN_OUT);
  assign we_prebuf_01  = wr_stb && (idx == `ACRB_IDX_PREBUF_01);
  assign we_prebuf_23  = wr_stb && (idx == `ACRB_IDX_PREBUF_23);
  assign we_refp_buf   = wr_stb && (idx == `ACRB_IDX_REFP_BUF);
  assign we_refn_buf   = wr_stb && (idx == `ACRB_IDX_REFN_BUF);
  assign we_ch0_ofs    = wr_stb && (idx == `ACRB_IDX_CH0_OFS);
  assign we_mod_delay  = wr_stb && (idx == `ACRB_IDX_MOD_DELAY);
  assign we_chop       = wr_stb && (idx == `ACRB_IDX_CHOP);

  // read mux; unused bits forced to zero
  always_comb begin
    known   = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `ACRB_IDX_STANDBY:    rd_byte = {4'h0, standby_r[3:0]};
      `ACRB_IDX_GRPA_FILT:  rd_byte = {4'h0, grpa_filt[3:0]};
      `ACRB_IDX_GRPB_FILT:  rd_byte = {4'h0, grpb_filt[3:0]};
      `ACRB_IDX_GRP_ASSIGN: rd_byte = grp_assign;
      `ACRB_IDX_POWER_IF:   rd_byte = power_if;
      `ACRB_IDX_GEN_CFG:    rd_byte = gen_cfg;
      `ACRB_IDX_CONV_CTRL:  rd_byte = conv_ctrl;
      `ACRB_IDX_OUT_IF:     rd_byte = {4'h0, out_if[3:0]};
      `ACRB_IDX_SELF_TEST:  rd_byte = {7'h00, self_test[0]};
      `ACRB_IDX_STATUS:     rd_byte = {4'h0, stat_sync};
      `ACRB_IDX_REVISION:   rd_byte = REVISION;
      `ACRB_IDX_RSVD_0B,
      `ACRB_IDX_RSVD_0C,
      `ACRB_IDX_RSVD_0D:    rd_byte = 8'h00;
      `ACRB_IDX_PIN_DIR:    rd_byte = pin_dir;
      `ACRB_IDX_PIN_OUT:    rd_byte = {3'h0, pin_out_r[4:0]};
      `ACRB_IDX_PIN_IN:     rd_byte = {3'h0, pin_sync};
      `ACRB_IDX_PREBUF_01:  rd_byte = prebuf_01;
      `ACRB_IDX_PREBUF_23:  rd_byte = prebuf_23;
      `ACRB_IDX_REFP_BUF:   rd_byte = refp_buf;
      `ACRB_IDX_REFN_BUF:   rd_byte = refn_buf;
      `ACRB_IDX_CH0_OFS:    rd_byte = ch0_ofs;
      `ACRB_IDX_MOD_DELAY:  rd_byte = {4'h0, mod_delay[3:0]};
      `ACRB_IDX_CHOP:       rd_byte = {4'h0, chop_ctrl[3:0]};
      default:              known   = 1'b0;
    endcase
  end

  // writable registers; read-only locations have no write path
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      standby_r  <= `ACRB_RST_STANDBY;
      grpa_filt  <= `ACRB_RST_FILT;
      grpb_filt  <= `ACRB_RST_FILT;
      grp_assign <= `ACRB_RST_ZERO;
      power_if   <= `ACRB_RST_ZERO;
      gen_cfg    <= `ACRB_RST_GEN_CFG;
      conv_ctrl  <= `ACRB_RST_CONV_CTRL;
      out_if     <= `ACRB_RST_ZERO;
      self_test  <= `ACRB_RST_ZERO;
      pin_dir    <= `ACRB_RST_ZERO;
      pin_out_r  <= `ACRB_RST_ZERO;
      prebuf_01  <= `ACRB_RST_PREBUF;
      prebuf_23  <= `ACRB_RST_PREBUF;
      refp_buf   <= `ACRB_RST_ZERO;
      refn_buf   <= `ACRB_RST_ZERO;
      ch0_ofs    <= `ACRB_RST_ZERO;
      mod_delay  <= `ACRB_RST_MOD_DELAY;
      chop_ctrl  <= `ACRB_RST_CHOP;
    end else begin
      if (we_standby)    standby_r  <= wr_byte;
      if (we_grpa_filt)  grpa_filt  <= wr_byte;
      if (we_grpb_filt)  grpb_filt  <= wr_byte;
      if (we_grp_assign) grp_assign <= wr_byte;
      if (we_power_if)   power_if   <= wr_byte;
      if (we_gen_cfg)    gen_cfg    <= wr_byte;
      if (we_conv_ctrl)  conv_ctrl  <= wr_byte;
      if (we_out_if)     out_if     <= wr_byte;
      if (we_self_test)  self_test  <= wr_byte;
      if (we_pin_dir)    pin_dir    <= wr_byte;
      if (we_pin_out)    pin_out_r  <= wr_byte;
      if (we_prebuf_01)  prebuf_01  <= wr_byte;
      if (we_prebuf_23)  prebuf_23  <= wr_byte;
      if (we_refp_buf)   refp_buf   <= wr_byte;
      if (we_refn_buf)   refn_buf   <= wr_byte;
      if (we_ch0_ofs)    ch0_ofs    <= wr_byte;
      if (we_mod_delay)  mod_delay  <= wr_byte;
      if (we_chop)       chop_ctrl  <= wr_byte;
    end
  end

  // apb answer: no wait state, data registered in setup
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= setup_ph;
      PSLVERR <= setup_ph && !hit;
      if (rd_stb) begin
        PRDATA <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // two-stage synchronisers for outside levels
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_meta  <= 5'h00;
      pin_sync  <= 5'h00;
      stat_meta <= 4'h0;
      stat_sync <= 4'h0;
    end else if (CE) begin
      pin_meta  <= PIN_IN;
      pin_sync  <= pin_meta;
      stat_meta <= STATUS_IN;
      stat_sync <= stat_meta;
    end
  end

  // delayed clock selection decode
  assign dly_sel = acrb_dly_sel_t'(
                   mod_delay[`ACRB_DLY_SEL_HI:`ACRB_DLY_SEL_LO]);
  assign dly_low4  = (dly_sel == ACRB_DLY_LOW4)
                     || (dly_sel == ACRB_DLY_ALL);
  assign dly_high4 = (dly_sel == ACRB_DLY_HIGH4)
                     || (dly_sel == ACRB_DLY_ALL);

  // one enable per channel: 0-3 low group, 4-7 high group
  for (genvar ch = 0; ch < 8; ch++) begin : g_dly_ch
    if (ch < 4) begin : g_low
      assign next_dly_en[ch] = dly_low4;
    end else begin : g_high
      assign next_dly_en[ch] = dly_high4;
    end
  end

  // chop rate fields per group
  assign grpa_rate = acrb_chop_t'(
                     chop_ctrl[`ACRB_FIRST_GROUP_CHOP_RATE_HI:`ACRB_FIRST_GROUP_CHOP_RATE_LO]);
  assign grpb_rate = acrb_chop_t'(
                     chop_ctrl[`ACRB_SECOND_GROUP_CHOP_RATE_HI:`ACRB_SECOND_GROUP_CHOP_RATE_LO]);

  acrb_chopper u_chop_a (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .CE       (CE),
    .mod_tick (MOD_TICK),
    .rate     (grpa_rate),
    .phase    (chop_ph.grpa)
  );

  acrb_chopper u_chop_b (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .CE       (CE),
    .mod_tick (MOD_TICK),
    .rate     (grpb_rate),
    .phase    (chop_ph.grpb)
  );

  // registered control outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DELAYED_CLK_EN    <= 8'h00;
      FIRST_GROUP_CHOP  <= 1'b0;
      SECOND_GROUP_CHOP <= 1'b0;
      STANDBY           <= 4'h0;
      PIN_OUT           <= 5'h00;
      PIN_OE            <= 5'h00;
    end else if (CE) begin
      DELAYED_CLK_EN    <= next_dly_en;
      FIRST_GROUP_CHOP  <= chop_ph.grpa;
      SECOND_GROUP_CHOP <= chop_ph.grpb;
      STANDBY           <= standby_r[3:0];
      PIN_OUT           <= pin_out_r[4:0];
      PIN_OE            <= pin_dir[4:0];
    end
  end

endmodule // acrb_config_bank

/* File: acrb_regs.svh */
`ifndef ACRB_REGS_SVH
`define ACRB_REGS_SVH

// register indices (byte address is four times the index)
`define ACRB_IDX_STANDBY     7'h00
`define ACRB_IDX_GRPA_FILT   7'h01
`define ACRB_IDX_GRPB_FILT   7'h02
`define ACRB_IDX_GRP_ASSIGN  7'h03
`define ACRB_IDX_POWER_IF    7'h04
`define ACRB_IDX_GEN_CFG     7'h05
`define ACRB_IDX_CONV_CTRL   7'h06
`define ACRB_IDX_OUT_IF      7'h07
`define ACRB_IDX_SELF_TEST   7'h08
`define ACRB_IDX_STATUS      7'h09
`define ACRB_IDX_REVISION    7'h0a
`define ACRB_IDX_RSVD_0B     7'h0b
`define ACRB_IDX_RSVD_0C     7'h0c
`define ACRB_IDX_RSVD_0D     7'h0d
`define ACRB_IDX_PIN_DIR     7'h0e
`define ACRB_IDX_PIN_OUT     7'h0f
`define ACRB_IDX_PIN_IN      7'h10
`define ACRB_IDX_PREBUF_01   7'h11
`define ACRB_IDX_PREBUF_23   7'h12
`define ACRB_IDX_REFP_BUF    7'h13
`define ACRB_IDX_REFN_BUF    7'h14
`define ACRB_IDX_CH0_OFS     7'h1e
`define ACRB_IDX_MOD_DELAY   7'h58
`define ACRB_IDX_CHOP        7'h59

// reset values
`define ACRB_RST_STANDBY     8'h00
`define ACRB_RST_FILT        8'h0d
`define ACRB_RST_GEN_CFG     8'h08
`define ACRB_RST_CONV_CTRL   8'h80
`define ACRB_RST_PREBUF      8'hff
`define ACRB_RST_ZERO        8'h00
`define ACRB_RST_MOD_DELAY   8'h02
`define ACRB_RST_CHOP        8'h0a

// field positions
`define ACRB_DLY_SEL_HI      3
`define ACRB_DLY_SEL_LO      2
`define ACRB_FIRST_GROUP_CHOP_RATE_HI    3
`define ACRB_FIRST_GROUP_CHOP_RATE_LO    2
`define ACRB_SECOND_GROUP_CHOP_RATE_HI    1
`define ACRB_SECOND_GROUP_CHOP_RATE_LO    0

// chop terminal counts in modulator ticks: phase toggles every 8 or 32 ticks
`define ACRB_CHOP_DIV_FAST   6'd7
`define ACRB_CHOP_DIV_SLOW   6'd31

`endif

/* File: acrb_pkg.sv */
package acrb_pkg;

  // delayed modulator clock selection codes
  typedef enum logic [1:0] {
    ACRB_DLY_NONE = 2'b00,
    ACRB_DLY_LOW4 = 2'b01,
    ACRB_DLY_HIGH4 = 2'b10,
    ACRB_DLY_ALL = 2'b11
  } acrb_dly_sel_t;

  // chop rate codes
  typedef enum logic [1:0] {
    ACRB_CHOP_OFF0 = 2'b00,
    ACRB_CHOP_DIV8 = 2'b01,
    ACRB_CHOP_DIV32 = 2'b10,
    ACRB_CHOP_OFF3 = 2'b11
  } acrb_chop_t;

  // apb request carried as one bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } acrb_apb_req_t;

  // chop state for two groups
  typedef struct packed {
    logic grpa;
    logic grpb;
  } acrb_chop_phase_t;

endpackage

/* File: acrb_chopper.sv */
`timescale 1ns/1ps
`include "acrb_regs.svh"

module acrb_chopper
  import acrb_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  // modulator tick and rate code
  input  wire logic       mod_tick,
  input  wire acrb_chop_t rate,
  // chop phase output
  output logic            phase
);

  logic [5:0] count;
  logic [5:0] limit;
  logic       active;

  // rate code to period: /8 or /32 of the modulator rate
  assign active = (rate == ACRB_CHOP_DIV8) || (rate == ACRB_CHOP_DIV32);
  assign limit  = (rate == ACRB_CHOP_DIV8) ? `ACRB_CHOP_DIV_FAST
                                           : `ACRB_CHOP_DIV_SLOW;

  // toggle phase each full period of modulator ticks
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      count <= 6'h00;
      phase <= 1'b0;
    end else if (CE && mod_tick) begin
      if (!active) begin
        count <= 6'h00;
        phase <= 1'b0;
      end else if (count >= limit) begin
        count <= 6'h00;
        phase <= ~phase;
      end else begin
        count <= count + 6'h01;
      end
    end
  end

endmodule // acrb_chopper

/* File: acrb_config_bank_monitor.sv */
`timescale 1ns/1ps
module acrb_config_bank_monitor
  import acrb_pkg::*;
(
  // clock, reset, enable
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  // apb slave side
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // decoded controls
  input wire logic [7:0]  DELAYED_CLK_EN,
  input wire logic        FIRST_GROUP_CHOP,
  input wire logic        SECOND_GROUP_CHOP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // setup phase, and a full write selecting every delayed channel
  sequence s_setup;
    PSEL && !PENABLE && CE;
  endsequence
  sequence s_dly_all_wr;
    s_setup ##0 PWRITE && PADDR == 32'h160 && PWDATA[3:2] == 2'b11 ##1 PREADY;
  endsequence

  chk_ready_pulse: assert property (s_setup |=> PREADY ##1 !PREADY)
    else $error("ready pulse wrong after setup");
  chk_bad_refused: assert property (
    s_setup ##0 !PWRITE && (PADDR[1:0] != 2'b00 || PADDR > 32'h1ff)
    |=> PREADY && PSLVERR && PRDATA == 32'h0)
    else $error("bad address not refused");
  chk_ro_no_err: assert property (
    s_setup ##0 PWRITE && PADDR inside {32'h24, 32'h28, 32'h2c, 32'h40}
    |=> PREADY && !PSLVERR)
    else $error("read only write flagged");
  chk_unused_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_dly_decode: assert property (
    DELAYED_CLK_EN inside {8'h00, 8'h0f, 8'hf0, 8'hff})
    else $error("delay enables not a group pattern");
  chk_dly_all_on: assert property (
    s_dly_all_wr |-> ##[1:3] DELAYED_CLK_EN == 8'hff)
    else $error("delay enables not all on");
  chk_reset_quiet: assert property (
    $rose(RST_N) |-> (DELAYED_CLK_EN == 8'h00 && !FIRST_GROUP_CHOP
                      && !SECOND_GROUP_CHOP) [*2])
    else $error("controls not idle after reset");
endmodule  // acrb_config_bank_monitor

bind acrb_config_bank acrb_config_bank_monitor u_mon (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .DELAYED_CLK_EN(DELAYED_CLK_EN),
  .FIRST_GROUP_CHOP(FIRST_GROUP_CHOP), .SECOND_GROUP_CHOP(SECOND_GROUP_CHOP)
);

/* File: acrb_config_bank_bench.sv */
`timescale 1ns/1ps
module acrb_config_bank_bench;
  import acrb_pkg::*;
  localparam logic [7:0] REV = 8'h3c;  // arbitrary identity value
  // register map indices and reset values
  localparam logic [6:0] IDX [24] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
    7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e,
    7'h0f, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h1e, 7'h58, 7'h59};
  localparam logic [7:0] RST [24] = '{8'h00, 8'h0d, 8'h0d, 8'h00, 8'h00,
    8'h08, 8'h80, 8'h00, 8'h00, 8'h00, REV, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0a};
  localparam logic [7:0]  DLY [4]  = '{8'h00, 8'h0f, 8'hf0, 8'hff};
  localparam logic [31:0] BAD [3]  = '{32'h161, 32'h54, 32'h200};
  localparam logic [6:0]  ROI [4]  = '{7'h09, 7'h0a, 7'h0b, 7'h10};
  localparam logic [7:0]  ROV [4]  = '{8'h0a, REV, 8'h00, 8'h15};
  localparam logic [7:0]  CHOP [3] = '{8'h06, 8'h09, 8'h00};
  localparam int          EA [3]   = '{32, 8, 0};
  localparam int          EB [3]   = '{8, 32, 0};
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0]  status_in, standby;
  logic [4:0]  pin_in, pin_out, pin_oe;
  logic [7:0]  dly_en;
  logic        mod_tick, chop_a, chop_b, ce;
  logic        pa = 1'b0;
  logic        pb = 1'b0;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          na = 0;
  int          nb = 0;
  int          a0, b0;

  acrb_config_bank #(.REVISION(REV)) dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STATUS_IN(status_in),
    .PIN_IN(pin_in), .MOD_TICK(mod_tick), .DELAYED_CLK_EN(dly_en),
    .FIRST_GROUP_CHOP(chop_a), .SECOND_GROUP_CHOP(chop_b),
    .STANDBY(standby), .PIN_OUT(pin_out), .PIN_OE(pin_oe)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // chop toggle counters and run limit
  always @(posedge clk) begin
    pa <= chop_a;
    pb <= chop_b;
    if (chop_a !== pa) na <= na + 1;
    if (chop_b !== pb) nb <= nb + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic near(int n, int e);
    return n >= e - 1 && n <= e + 1;
  endfunction

  // one apb transfer, request held until ready is sampled
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input string nm, input logic [6:0] i, input logic [7:0] e);
    apb(1'b0, {23'h0, i, 2'b00}, 32'h0);
    chk(nm, {rerr, rdat}, {25'h0, e});
  endtask

  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    apb(1'b1, {23'h0, i, 2'b00}, {24'h0, d});
    chk("write resp", {32'h0, rerr}, 33'h0);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, mod_tick} = 4'h0;
    ce = 1'b1;
    paddr = 32'h0;
    pwdata = 32'h0;
    status_in = 4'h0;
    pin_in = 5'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 24; i++)
      rd("reset", IDX[i], RST[i]);
    chk("delay en", {25'h0, dly_en}, 33'h0);
    for (int c = 0; c < 4; c++) begin
      wr(7'h58, {4'hf, c[1:0], 2'b10});
      rd("delay reg", 7'h58, {4'h0, c[1:0], 2'b10});
      repeat (2) @(posedge clk);
      chk("delay en", {25'h0, dly_en}, {25'h0, DLY[c]});
    end
    apb(1'b1, 32'h161, 32'h2);
    chk("refused wr", {32'h0, rerr}, 33'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, BAD[i], 32'h0);
      chk("refused", {rerr, rdat}, {1'b1, 32'h0});
    end
    rd("delay kept", 7'h58, 8'h0e);
    status_in <= 4'ha;
    pin_in <= 5'h15;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wr(ROI[i], 8'hff);
      rd("read only", ROI[i], ROV[i]);
    end
    wr(7'h00, 8'hf5);
    wr(7'h0e, 8'h0c);
    wr(7'h0f, 8'h1a);
    rd("standby", 7'h00, 8'h05);
    rd("pin out", 7'h0f, 8'h1a);
    chk("pins", {19'h0, standby, pin_oe, pin_out}, {19'h0, 14'h159a});
    wr(7'h59, 8'h05);
    ce <= 1'b0;
    a0 = na;
    b0 = nb;
    repeat (64) begin
      mod_tick <= 1'b1;
      @(posedge clk);
      mod_tick <= 1'b0;
      @(posedge clk);
    end
    ce <= 1'b1;
    chk("frozen a", {1'b0, na - a0}, 33'h0);
    chk("frozen b", {1'b0, nb - b0}, 33'h0);
    for (int k = 0; k < 3; k++) begin
      wr(7'h59, CHOP[k]);
      rd("chop reg", 7'h59, CHOP[k]);
      a0 = na;
      b0 = nb;
      repeat (256) begin
        mod_tick <= 1'b1;
        @(posedge clk);
        mod_tick <= 1'b0;
        @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk("chop a", {32'h0, near(na - a0, EA[k])}, 33'h1);
      chk("chop b", {32'h0, near(nb - b0, EB[k])}, 33'h1);
    end
    chk("chop idle", {31'h0, chop_a, chop_b}, 33'h0);
    test_done();
  end
endmodule  // acrb_config_bank_bench
